// ==== src/dcc_top.sv ====
// per-converter clear control: software, pin and alarm clear sources
`include "dcc_map.svh"
`default_nettype none
module dcc_top (
	// clock, reset and enable
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// decoded register access from the serial interface
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire dcc_pkg::dcc_addr_t i_addr,
	input wire dcc_pkg::dcc_word_t i_wdata,
	output dcc_pkg::dcc_word_t o_rdata,
	// external active-low clear pins
	input wire logic i_force_input_a_n,
	input wire logic i_force_input_b_n,
	// alarm clear requests from neighbouring logic, same clock
	input wire dcc_pkg::dcc_mask_t i_alarm_force,
	// per-converter clear state
	output dcc_pkg::dcc_mask_t o_dac_clear
);
	import dcc_pkg::*;

	// ===================================================================
	// register storage and internal signals
	dcc_mask_t software_clear_reg; // software_force_bits field
	dcc_mask_t pin0_clear_enable_reg; // pin_a_force_enable field
	dcc_mask_t pin1_clear_enable_reg; // pin_b_force_enable field
	dcc_mask_t dac_clear_next; // combined clear request
	dcc_mask_t pin_a_mask; // converters forced by pin a
	dcc_mask_t pin_b_mask; // converters forced by pin b
	dcc_word_t rdata_next; // read mux result
	logic [1:0] pins_sync_n; // synchronised pins, bit0 a, bit1 b
	logic pin_a_low; // pin a asserted, synchronised
	logic pin_b_low; // pin b asserted, synchronised
	logic wr_cycle; // write takes effect this cycle

	// ===================================================================
	// pin synchronisation
	// the pins come from board logic with no relation to i_mclk
	dcc_sync #(
		.W(2)
	) u_pin_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async({i_force_input_b_n, i_force_input_a_n}),
		.o_sync(pins_sync_n)
	);

	assign pin_a_low = !pins_sync_n[0];
	assign pin_b_low = !pins_sync_n[1];
	assign wr_cycle = i_ce && i_wr_en;

	// ===================================================================
	// software clear register
	// a write stores the field; reserved bits are dropped
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			software_clear_reg <= dcc_mask_t'(`DCC_RST_SW_CLEAR);
		end else if (wr_cycle && i_addr == `DCC_ADDR_SW_CLEAR) begin
			software_clear_reg <= i_wdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB];
		end
	end

	// ===================================================================
	// pin-a clear enable register
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin0_clear_enable_reg <= dcc_mask_t'(`DCC_RST_PIN0_EN);
		end else if (wr_cycle && i_addr == `DCC_ADDR_PIN0_EN) begin
			pin0_clear_enable_reg <= i_wdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB];
		end
	end

	// ===================================================================
	// pin-b clear enable register
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin1_clear_enable_reg <= dcc_mask_t'(`DCC_RST_PIN1_EN);
		end else if (wr_cycle && i_addr == `DCC_ADDR_PIN1_EN) begin
			pin1_clear_enable_reg <= i_wdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB];
		end
	end

	// ===================================================================
	// clear source combination
	// a disabled converter ignores its pin entirely
	always_comb begin
		pin_a_mask = pin_a_low ? pin0_clear_enable_reg : '0;
		pin_b_mask = pin_b_low ? pin1_clear_enable_reg : '0;
		// any source holds the converter clear; all must let go
		dac_clear_next = software_clear_reg | pin_a_mask | pin_b_mask |
			i_alarm_force;
	end

	// ===================================================================
	// clear state output register
	// registered so the converters never see a decode glitch
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dac_clear <= '0;
		end else if (i_ce) begin
			o_dac_clear <= dac_clear_next;
		end
	end

	// ===================================================================
	// read back
	// reserved bits read as zero; unmapped addresses answer zero
	always_comb begin
		rdata_next = `DCC_RDATA_UNMAPPED;
		unique case (i_addr)
			`DCC_ADDR_SW_CLEAR: begin
				rdata_next[`DCC_FIELD_MSB:`DCC_FIELD_LSB] = software_clear_reg;
			end
			`DCC_ADDR_PIN0_EN: begin
				rdata_next[`DCC_FIELD_MSB:`DCC_FIELD_LSB] =
					pin0_clear_enable_reg;
			end
			`DCC_ADDR_PIN1_EN: begin
				rdata_next[`DCC_FIELD_MSB:`DCC_FIELD_LSB] =
					pin1_clear_enable_reg;
			end
			default: begin
				rdata_next = `DCC_RDATA_UNMAPPED;
			end
		endcase
	end

	// read data holds until the next read
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_ce && i_rd_en) begin
			o_rdata <= rdata_next;
		end
	end

	// ===================================================================
	// checks
	// software bits must appear in the clear state one cycle later
	a_sw_force_held: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$past(i_ce) |-> ((o_dac_clear & $past(software_clear_reg)) ==
		$past(software_clear_reg)))
		else $error("software clear bit not reflected");

	// enabled converters clear while pin a is low
	a_pin_a_force: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(i_ce) && $past(pin_a_low)) |->
		((o_dac_clear & $past(pin0_clear_enable_reg)) ==
		$past(pin0_clear_enable_reg)))
		else $error("pin a did not clear enabled converter");

	// with only pin a active, exactly the enabled set is cleared
	a_pin_a_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(i_ce) && $past(software_clear_reg) == '0 &&
		$past(i_alarm_force) == '0 && !$past(pin_b_low)) |->
		(o_dac_clear == ($past(pin_a_low) ?
		$past(pin0_clear_enable_reg) : '0)))
		else $error("pin a touched a disabled converter");

	// enabled converters clear while pin b is low
	a_pin_b_force: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(i_ce) && $past(pin_b_low)) |->
		((o_dac_clear & $past(pin1_clear_enable_reg)) ==
		$past(pin1_clear_enable_reg)))
		else $error("pin b did not clear enabled converter");

	// with only pin b active, exactly the enabled set is cleared
	a_pin_b_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(i_ce) && $past(software_clear_reg) == '0 &&
		$past(i_alarm_force) == '0 && !$past(pin_a_low)) |->
		(o_dac_clear == ($past(pin_b_low) ?
		$past(pin1_clear_enable_reg) : '0)))
		else $error("pin b touched a disabled converter");

	// a write at 56h lands in the pin-a enable
	a_pin0_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(wr_cycle) && $past(i_addr) == `DCC_ADDR_PIN0_EN) |->
		(pin0_clear_enable_reg ==
		$past(i_wdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB])))
		else $error("pin a enable write lost");

	// a write at 57h lands in the pin-b enable
	a_pin1_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(wr_cycle) && $past(i_addr) == `DCC_ADDR_PIN1_EN) |->
		(pin1_clear_enable_reg ==
		$past(i_wdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB])))
		else $error("pin b enable write lost");

	// a write at 55h shows up in read back after a read in the very next cycle
	a_sw_readback: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(wr_cycle) && $past(i_addr) == `DCC_ADDR_SW_CLEAR) ##0
		(i_ce && i_rd_en && i_addr == `DCC_ADDR_SW_CLEAR && !i_wr_en) |=>
		(o_rdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB] ==
		$past(i_wdata[`DCC_FIELD_MSB:`DCC_FIELD_LSB], 2)))
		else $error("software clear read back wrong");

	// with every source quiet, all converters return to normal
	a_all_release: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		($past(i_ce) && $past(software_clear_reg) == '0 &&
		$past(i_alarm_force) == '0 && !$past(pin_a_low) &&
		!$past(pin_b_low)) |-> (o_dac_clear == '0))
		else $error("converter held clear with no source");
endmodule
`default_nettype wire

// ==== src/dcc_map.svh ====
// register offsets, field positions and reset values of the clear control
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// register addresses on the internal register port
`define DCC_ADDR_SW_CLEAR 8'h55
`define DCC_ADDR_PIN0_EN 8'h56
`define DCC_ADDR_PIN1_EN 8'h57

// per-converter field inside each 16-bit register
`define DCC_FIELD_MSB 14
`define DCC_FIELD_LSB 3

// reset values
`define DCC_RST_SW_CLEAR 16'h0000
`define DCC_RST_PIN0_EN 16'h0000
`define DCC_RST_PIN1_EN 16'h0000

// answer to an unmapped read
`define DCC_RDATA_UNMAPPED 16'h0000

`endif

// ==== src/dcc_pkg.sv ====
// shared types of the converter clear control block
`default_nettype none
package dcc_pkg;
	// number of converters handled
	localparam int DCC_NUM_DAC = 12;
	// one bit per converter
	typedef logic [DCC_NUM_DAC-1:0] dcc_mask_t;
	// register address and data words
	typedef logic [7:0] dcc_addr_t;
	typedef logic [15:0] dcc_word_t;
endpackage
`default_nettype wire

// ==== src/dcc_sync.sv ====
// two flip-flop level synchroniser for asynchronous pins
`default_nettype none
module dcc_sync #(
	parameter int W = 1
) (
	// clock, reset and enable
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	// first stage, read only by the second stage
	logic [W-1:0] meta_reg;

	// ===================================================================
	// synchroniser chain
	// idle level of the active-low pins is high, so reset to ones
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= '1;
			o_sync <= '1;
		end else if (i_ce) begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ==== tb/dcc_pin_model.sv ====
// external logic pulling the two clear pins
`default_nettype none
module dcc_pin_model (
	// timing reference
	input wire logic i_mclk,
	// high asks for that pin to be pulled low
	input wire logic i_req_a,
	input wire logic i_req_b,
	// open-collector pins, board pull-ups give high when released
	output var logic o_force_input_a_n,
	output var logic o_force_input_b_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// pin drive
	initial begin
		o_force_input_a_n = 1'b1;
		o_force_input_b_n = 1'b1;
	end
	// pins move off the clock grid, as true asynchronous lines would
	always @(negedge i_mclk) begin
		#7;
		o_force_input_a_n <= ~i_req_a;
		o_force_input_b_n <= ~i_req_b;
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the converter clear control
`include "dcc_map.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dcc_pkg::*;
	// ====
	// stimulus and observed signals
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_ce = 1'b1;
	logic i_wr_en = 1'b0;
	logic i_rd_en = 1'b0;
	dcc_addr_t i_addr = 8'h00;
	dcc_word_t i_wdata = 16'h0000;
	dcc_mask_t i_alarm_force = 12'h000;
	logic req_a = 1'b0;
	logic req_b = 1'b0;
	logic pin_a_n;
	logic pin_b_n;
	dcc_word_t o_rdata;
	dcc_mask_t o_dac_clear;
	// reference copies of the stored fields
	dcc_mask_t sw_m = 12'h000;
	dcc_mask_t p0_m = 12'h000;
	dcc_mask_t p1_m = 12'h000;
	dcc_word_t exp_q[$];
	logic taken = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	dcc_pin_model pins (.i_mclk(i_mclk), .i_req_a(req_a), .i_req_b(req_b),
		.o_force_input_a_n(pin_a_n), .o_force_input_b_n(pin_b_n));
	dcc_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_force_input_a_n(pin_a_n), .i_force_input_b_n(pin_b_n),
		.i_alarm_force(i_alarm_force), .o_dac_clear(o_dac_clear));
	initial begin
		forever #25 i_mclk = ~i_mclk;
	end
	// ====
	// shared tasks
	task automatic check(string name, logic [15:0] e, logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, e, s);
		end
	endtask
	task automatic wr(dcc_addr_t a, dcc_word_t d);
		@(posedge i_mclk);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr_en <= 1'b0;
	endtask
	// the expectation is queued, the monitor below compares it
	task automatic rd(dcc_addr_t a, dcc_word_t e);
		@(posedge i_mclk);
		i_rd_en <= 1'b1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_mclk);
		i_rd_en <= 1'b0;
	endtask
	// write, then read back in the very next cycle with reserved bits zero;
	// back to back on purpose, so the read sees the freshly stored field
	task automatic setreg(dcc_addr_t a, dcc_word_t d);
		@(posedge i_mclk);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b1;
		exp_q.push_back(d & 16'h7FF8);
		if (a == `DCC_ADDR_SW_CLEAR) begin
			sw_m = d[`DCC_FIELD_MSB:`DCC_FIELD_LSB];
		end
		if (a == `DCC_ADDR_PIN0_EN) begin
			p0_m = d[`DCC_FIELD_MSB:`DCC_FIELD_LSB];
		end
		if (a == `DCC_ADDR_PIN1_EN) begin
			p1_m = d[`DCC_FIELD_MSB:`DCC_FIELD_LSB];
		end
		@(posedge i_mclk);
		i_rd_en <= 1'b0;
	endtask
	// any requesting source holds a converter clear
	task automatic settle(int n, string name);
		dcc_mask_t e;
		repeat (n) @(posedge i_mclk);
		#1;
		e = sw_m | (req_a ? p0_m : 12'h000) | (req_b ? p1_m : 12'h000);
		e = e | i_alarm_force;
		check(name, {4'h0, e}, {4'h0, o_dac_clear});
		$display("test %s done", name);
	endtask
	task automatic end_sim();
		if (exp_q.size() != 0) n_errors++;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ====
	// read data monitor: data shows at the read edge, checked on the next falling edge
	always @(posedge i_mclk) begin
		taken <= i_rd_en & i_ce & i_rst_n;
	end
	always @(negedge i_mclk) begin
		if (taken && exp_q.size() > 0) begin
			check("o_rdata", exp_q.pop_front(), o_rdata);
		end else if (taken) begin
			check("o_rdata_unexpected", 16'h0000, 16'hFFFF);
		end
	end
	// watchdog: a hung run is a failure
	initial begin
		#1000000;
		check("run_end", 16'h0000, 16'hFFFF);
		end_sim();
	end
	// ====
	// main sequence
	initial begin
		void'($urandom(32'hBFA6));
		repeat (8) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rd(`DCC_ADDR_SW_CLEAR, `DCC_RST_SW_CLEAR);
		rd(`DCC_ADDR_PIN0_EN, `DCC_RST_PIN0_EN);
		rd(`DCC_ADDR_PIN1_EN, `DCC_RST_PIN1_EN);
		rd(8'h58, `DCC_RDATA_UNMAPPED);
		settle(1, "reset_values");
		// software clear, the last three rounds with alarms on top
		for (int i = 0; i < 6; i++) begin
			setreg(`DCC_ADDR_SW_CLEAR, 16'($urandom));
			i_alarm_force <= (i > 2) ? 12'($urandom) : 12'h000;
			settle(2, "software_alarm");
		end
		setreg(`DCC_ADDR_SW_CLEAR, 16'h0000);
		// every pin combination, random enables, some with alarms
		for (int i = 0; i < 8; i++) begin
			setreg(`DCC_ADDR_PIN0_EN, 16'($urandom));
			setreg(`DCC_ADDR_PIN1_EN, 16'($urandom));
			req_a <= i[0];
			req_b <= i[1];
			i_alarm_force <= i[2] ? 12'($urandom) : 12'h000;
			settle(5, "pin_clear");
		end
		req_a <= 1'b0;
		req_b <= 1'b0;
		i_alarm_force <= 12'h000;
		settle(5, "release_all");
		// unmapped and clock-disabled writes leave the registers alone
		wr(8'h58, 16'hFFFF);
		i_ce <= 1'b0;
		wr(`DCC_ADDR_SW_CLEAR, 16'hFFFF);
		i_ce <= 1'b1;
		rd(`DCC_ADDR_SW_CLEAR, {1'b0, sw_m, 3'h0});
		rd(`DCC_ADDR_PIN0_EN, {1'b0, p0_m, 3'h0});
		rd(`DCC_ADDR_PIN1_EN, {1'b0, p1_m, 3'h0});
		settle(2, "ignored_writes");
		end_sim();
	end
endmodule
`default_nettype wire
